// file: rtl/fence_cfg.svh
`ifndef FENCE_CFG_SVH
`define FENCE_CFG_SVH

// Register byte offsets
`define REG_CTRL      8'h00
`define REG_SIGMA     8'h04
`define REG_STATUS    8'h08
`define REG_IRQ_STS   8'h0C
`define REG_IRQ_CLR   8'h10
`define REG_IRQ_EN    8'h14
`define FENCE_BASE    8'h20
`define FENCE_FLD_X   2'h0
`define FENCE_FLD_Y   2'h1
`define FENCE_FLD_RAD 2'h2

// Field positions
`define CTRL_PIN_EN   4
`define CTRL_POL      5
`define CTRL_BACKUP   6
`define STS_FENCE_LSB 2
`define STS_ACTIVE    10
`define IRQ_REPORT    0
`define IRQ_CHANGE    1

// Reset values and answers
`define SIGMA_RST     8'h01
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// file: rtl/fence_eval.sv
`timescale 1ns/100ps
`default_nettype none
module fence_eval
	import fence_pkg::*;
#(
	parameter int NF = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration in, results out
	fence_if.eval    m
);
	typedef struct packed {
		eval_state_t      st;
		fstate_t [NF-1:0] fs;
		fstate_t          comb;
		logic             done;
		logic [NF-1:0]    mask;
	} ev_t;

	ev_t q;
	ev_t n;
	logic any_in;
	logic all_out;

	// Scaled uncertainty circle must sit wholly inside or outside the fence
	function automatic fstate_t classify(input logic [15:0] px, input logic [15:0] py,
		input logic [15:0] cx, input logic [15:0] cy, input logic [15:0] r,
		input logic [15:0] sd, input logic [7:0] sg);
		logic signed [33:0] dx;
		logic signed [33:0] dy;
		logic [34:0]        d2;
		logic [23:0]        u;
		logic [49:0]        ro;
		logic [49:0]        ri;
		dx = 34'($signed(px)) - 34'($signed(cx));
		dy = 34'($signed(py)) - 34'($signed(cy));
		d2 = 35'($unsigned(dx * dx)) + 35'($unsigned(dy * dy));
		u = {8'h00, sd} * {16'h0000, sg};
		ro = {25'h0000000, {9'h000, r} + {1'b0, u}};
		ri = {25'h0000000, {9'h000, r} - {1'b0, u}};
		if ({8'h00, r} > u && {15'h0000, d2} <= ri * ri) begin
			classify = FS_INSIDE;
		end else if ({15'h0000, d2} >= ro * ro) begin
			classify = FS_OUTSIDE;
		end else begin
			classify = FS_UNKNOWN;
		end
	endfunction

	always_comb begin
		n = q;
		n.done = 1'b0;
		any_in = 1'b0;
		all_out = 1'b1;
		n.st = (m.fen != '0) ? EV_ARMED : EV_IDLE;
		if (m.fen == '0) begin
			n.fs = {NF{FS_UNKNOWN}};
			n.comb = FS_UNKNOWN;
			n.mask = '0;
		end else if (m.epoch) begin
			for (int i = 0; i < NF; i++) begin
				n.fs[i] = FS_UNKNOWN;
				if (m.fen[i] && m.pos_valid) begin
					n.fs[i] = classify(m.pos_x, m.pos_y, m.cx[i], m.cy[i], m.rad[i],
						m.pos_std, m.sigma);
				end
				if (m.fen[i] && n.fs[i] == FS_INSIDE) begin
					any_in = 1'b1;
				end
				if (m.fen[i] && n.fs[i] != FS_OUTSIDE) begin
					all_out = 1'b0;
				end
			end
			n.comb = any_in ? FS_INSIDE : (all_out ? FS_OUTSIDE : FS_UNKNOWN);
			n.mask = m.fen;
			n.done = 1'b1;
			n.st = EV_REPORT;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= EV_IDLE;
		end else begin
			q <= n;
		end
	end

	assign m.fs = q.fs;
	assign m.comb = q.comb;
	assign m.done = q.done;
	assign m.active = (q.st != EV_IDLE);

	// Reference view of the combination, read only by the checks
	logic chk_in;
	logic chk_out;
	always_comb begin
		chk_in = 1'b0;
		chk_out = 1'b1;
		for (int i = 0; i < NF; i++) begin
			if (q.mask[i] && q.fs[i] == FS_INSIDE) begin
				chk_in = 1'b1;
			end
			if (q.mask[i] && q.fs[i] != FS_OUTSIDE) begin
				chk_out = 1'b0;
			end
		end
	end

	sequence s_epoch_live;
		m.epoch && m.fen != '0;
	endsequence
	property p_epoch_report;
		@(posedge clk_i) disable iff (rst_i) s_epoch_live |=> q.done && q.st == EV_REPORT;
	endproperty
	a_epoch_report: assert property (p_epoch_report) else $error("epoch not evaluated");
	property p_idle_quiet;
		@(posedge clk_i) disable iff (rst_i) m.fen == '0 |=> !q.done ##1 q.st == EV_IDLE || m.fen != '0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("report while no fence set");
	property p_invalid_unknown;
		@(posedge clk_i) disable iff (rst_i)
			s_epoch_live and !m.pos_valid |=> q.comb == FS_UNKNOWN && q.fs == {NF{FS_UNKNOWN}};
	endproperty
	a_invalid_unknown: assert property (p_invalid_unknown) else $error("no fix not unknown");
	property p_comb_in;
		@(posedge clk_i) disable iff (rst_i) q.done && chk_in |-> q.comb == FS_INSIDE;
	endproperty
	a_comb_in: assert property (p_comb_in) else $error("combined inside missed");
	property p_comb_out;
		@(posedge clk_i) disable iff (rst_i) q.done && !chk_in && chk_out |-> q.comb == FS_OUTSIDE;
	endproperty
	a_comb_out: assert property (p_comb_out) else $error("combined outside missed");
	property p_comb_unk;
		@(posedge clk_i) disable iff (rst_i) q.done && !chk_in && !chk_out |-> q.comb == FS_UNKNOWN;
	endproperty
	a_comb_unk: assert property (p_comb_unk) else $error("combined unknown missed");
endmodule
`default_nettype wire

// file: rtl/fence_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fence_if
	import fence_pkg::*;
#(
	parameter int NF = 4
);
	logic                  epoch;
	logic                  pos_valid;
	logic [15:0]           pos_x;
	logic [15:0]           pos_y;
	logic [15:0]           pos_std;
	logic [NF-1:0]         fen;
	logic [7:0]            sigma;
	logic [NF-1:0][15:0]   cx;
	logic [NF-1:0][15:0]   cy;
	logic [NF-1:0][15:0]   rad;
	fstate_t [NF-1:0]      fs;
	fstate_t               comb;
	logic                  done;
	logic                  active;

	modport cfg (output epoch, pos_valid, pos_x, pos_y, pos_std, fen, sigma, cx, cy, rad,
		input fs, comb, done, active);
	modport eval (input epoch, pos_valid, pos_x, pos_y, pos_std, fen, sigma, cx, cy, rad,
		output fs, comb, done, active);
endinterface
`default_nettype wire

// file: rtl/fence_pin.sv
`timescale 1ns/100ps
`default_nettype none
module fence_pin
	import fence_pkg::*;
(
	// Clock and reset
	input wire logic    clk_i,
	input wire logic    rst_i,
	// Control
	input wire logic    pin_en_i,
	input wire logic    pol_i,
	input wire logic    backup_i,
	input wire fstate_t comb_i,
	// Pin level
	output logic        pin_o
);
	typedef struct packed {
		logic pin;
	} pin_t;

	pin_t q;
	pin_t n;

	always_comb begin
		n.pin = 1'b1;
		if (pin_en_i && !backup_i && comb_i != FS_UNKNOWN) begin
			n.pin = (comb_i == FS_INSIDE) ? pol_i : !pol_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q.pin <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign pin_o = q.pin;

	property p_reset_high;
		@(posedge clk_i) rst_i |=> pin_o;
	endproperty
	a_reset_high: assert property (p_reset_high) else $error("pin low after reset");
	property p_backup_high;
		@(posedge clk_i) disable iff (rst_i) backup_i |=> pin_o;
	endproperty
	a_backup_high: assert property (p_backup_high) else $error("pin low in backup");
	property p_unknown_high;
		@(posedge clk_i) disable iff (rst_i) comb_i == FS_UNKNOWN |=> pin_o;
	endproperty
	a_unknown_high: assert property (p_unknown_high) else $error("unknown not high");
	property p_polarity;
		@(posedge clk_i) disable iff (rst_i)
			pin_en_i && !backup_i && comb_i == FS_INSIDE |=> pin_o == $past(pol_i);
	endproperty
	a_polarity: assert property (p_polarity) else $error("inside level wrong");
	property p_follow_out;
		@(posedge clk_i) disable iff (rst_i)
			pin_en_i && !backup_i && comb_i == FS_OUTSIDE |=> pin_o != $past(pol_i);
	endproperty
	a_follow_out: assert property (p_follow_out) else $error("outside level wrong");
endmodule
`default_nettype wire

// file: rtl/fence_pkg.sv
package fence_pkg;

	typedef enum logic [1:0] {
		FS_UNKNOWN = 2'b00,
		FS_INSIDE  = 2'b01,
		FS_OUTSIDE = 2'b10
	} fstate_t;

	typedef enum logic [2:0] {
		EV_IDLE   = 3'b001,
		EV_ARMED  = 3'b010,
		EV_REPORT = 3'b100
	} eval_state_t;

endpackage

// file: rtl/geofence_state_evaluator.sv
// Contract
// - Up to four circular fences, each judged on its own.
// - Evaluation runs only while some fence is configured; idle otherwise.
// - Every navigation epoch the position is judged against all configured fences.
// - Every epoch while some fence is configured, each fence state and the combined state are reported.
// - Each fence is exactly one of inside, outside or unknown.
// - No valid fix or too much uncertainty gives unknown.
// - Standard deviation times sigma multiplier widens the position circle.
// - Combined inside when any configured fence is inside.
// - Combined outside only when every configured fence is outside.
// - Every other case gives combined unknown.
// - When enabled, the pin follows the combined state.
// - Combined unknown drives the pin high whatever the polarity.
// - Reset or software backup drives the pin high.
// - Polarity picks whether low means inside or outside.
`timescale 1ns/100ps
`default_nettype none
`include "fence_cfg.svh"
module geofence_state_evaluator
	import fence_pkg::*;
#(
	parameter int NF = 4
) (
	// Clock and reset
	input wire logic         REF_CLK_I,
	input wire logic         RST_I,
	// AXI4-Lite write channels
	input wire logic [7:0]   S_AXI_AWADDR_I,
	input wire logic         S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input wire logic [31:0]  S_AXI_WDATA_I,
	input wire logic [3:0]   S_AXI_WSTRB_I,
	input wire logic         S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input wire logic         S_AXI_BREADY_I,
	// AXI4-Lite read channels
	input wire logic [7:0]   S_AXI_ARADDR_I,
	input wire logic         S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input wire logic         S_AXI_RREADY_I,
	// Position solution
	input wire logic         EPOCH_I,
	input wire logic         POS_VALID_I,
	input wire logic [15:0]  POS_X_I,
	input wire logic [15:0]  POS_Y_I,
	input wire logic [15:0]  POS_STD_I,
	// Outputs to the host
	output logic             GEOFENCE_PIN_O,
	output logic             IRQ_O
);
	typedef struct packed {
		logic       hit;
		logic       fence;
		logic [1:0] idx;
		logic [1:0] fld;
	} dec_t;

	typedef struct packed {
		logic [NF-1:0][15:0] cx;
		logic [NF-1:0][15:0] cy;
		logic [NF-1:0][15:0] rad;
		logic [NF-1:0]       fen;
		logic                fence_pin_polarity;
		logic                pin_en;
		logic                backup;
		logic [7:0]          sigma;
		logic [1:0]          irq_sts;
		logic [1:0]          irq_en;
		logic                irq;
		fstate_t             comb_prev;
		logic [7:0]          awaddr;
		logic                aw_have;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                w_have;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} regs_t;

	regs_t       q;
	regs_t       n;
	dec_t        wdec;
	dec_t        rdec;
	logic [31:0] wd;
	logic [1:0]  ev;
	logic [1:0]  clr;
	logic        pin_q;

	fence_if #(.NF(NF)) fif ();

	function automatic dec_t decode(input logic [7:0] a);
		logic [7:0] off;
		off = a - `FENCE_BASE;
		decode = '0;
		if (a[1:0] == 2'h0) begin
			if (a >= `FENCE_BASE && off[7:4] < 4'(NF) && off[3:2] <= `FENCE_FLD_RAD) begin
				decode.hit = 1'b1;
				decode.fence = 1'b1;
				decode.idx = off[5:4];
				decode.fld = off[3:2];
			end else begin
				decode.hit = (a <= `REG_IRQ_EN);
			end
		end
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[8*b +: 8] = nw[8*b +: 8];
			end
		end
	endfunction

	function automatic logic [31:0] rd_word(input dec_t d, input logic [7:0] a);
		rd_word = 32'h00000000;
		if (d.fence) begin
			case (d.fld)
				`FENCE_FLD_X: rd_word[15:0] = q.cx[d.idx];
				`FENCE_FLD_Y: rd_word[15:0] = q.cy[d.idx];
				default: rd_word[15:0] = q.rad[d.idx];
			endcase
		end else begin
			case (a)
				`REG_CTRL: begin
					rd_word[NF-1:0] = q.fen;
					rd_word[`CTRL_PIN_EN] = q.pin_en;
					rd_word[`CTRL_POL] = q.fence_pin_polarity;
					rd_word[`CTRL_BACKUP] = q.backup;
				end
				`REG_SIGMA: rd_word[7:0] = q.sigma;
				`REG_STATUS: begin
					rd_word[1:0] = fif.comb;
					rd_word[`STS_FENCE_LSB +: 2*NF] = fif.fs;
					rd_word[`STS_ACTIVE] = fif.active;
				end
				`REG_IRQ_STS: rd_word[1:0] = q.irq_sts;
				`REG_IRQ_EN: rd_word[1:0] = q.irq_en;
				default: rd_word = 32'h00000000;
			endcase
		end
	endfunction

	always_comb begin
		n = q;
		wd = 32'h00000000;
		clr = 2'b00;
		ev = 2'b00;
		wdec = decode(q.awaddr);
		rdec = decode(S_AXI_ARADDR_I);
		if (S_AXI_AWVALID_I && q.awready) begin
			n.awaddr = S_AXI_AWADDR_I;
			n.aw_have = 1'b1;
		end
		if (S_AXI_WVALID_I && q.wready) begin
			n.wdata = S_AXI_WDATA_I;
			n.wstrb = S_AXI_WSTRB_I;
			n.w_have = 1'b1;
		end
		if (q.bvalid && S_AXI_BREADY_I) begin
			n.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wdec.hit ? `RESP_OKAY : `RESP_SLVERR;
			wd = merge(rd_word(wdec, q.awaddr), q.wdata, q.wstrb);
			if (wdec.hit && wdec.fence) begin
				case (wdec.fld)
					`FENCE_FLD_X: n.cx[wdec.idx] = wd[15:0];
					`FENCE_FLD_Y: n.cy[wdec.idx] = wd[15:0];
					default: n.rad[wdec.idx] = wd[15:0];
				endcase
			end else if (wdec.hit) begin
				case (q.awaddr)
					`REG_CTRL: begin
						n.fen = wd[NF-1:0];
						n.pin_en = wd[`CTRL_PIN_EN];
						n.fence_pin_polarity = wd[`CTRL_POL];
						n.backup = wd[`CTRL_BACKUP];
					end
					`REG_SIGMA: n.sigma = wd[7:0];
					`REG_IRQ_CLR: clr = wd[1:0];
					`REG_IRQ_EN: n.irq_en = wd[1:0];
					default: n.irq_en = q.irq_en;
				endcase
			end
		end
		if (q.rvalid && S_AXI_RREADY_I) begin
			n.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && q.arready) begin
			n.rvalid = 1'b1;
			n.rdata = rd_word(rdec, S_AXI_ARADDR_I);
			n.rresp = rdec.hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (fif.done) begin
			ev[`IRQ_REPORT] = 1'b1;
			ev[`IRQ_CHANGE] = (fif.comb != q.comb_prev);
			n.comb_prev = fif.comb;
		end
		n.irq_sts = (q.irq_sts & ~clr) | ev;
		n.irq = |(n.irq_sts & n.irq_en);
		n.awready = !n.aw_have && !n.bvalid;
		n.wready = !n.w_have && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			q <= '0;
			q.sigma <= `SIGMA_RST;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign fif.epoch = EPOCH_I;
	assign fif.pos_valid = POS_VALID_I;
	assign fif.pos_x = POS_X_I;
	assign fif.pos_y = POS_Y_I;
	assign fif.pos_std = POS_STD_I;
	assign fif.fen = q.fen;
	assign fif.sigma = q.sigma;
	assign fif.cx = q.cx;
	assign fif.cy = q.cy;
	assign fif.rad = q.rad;

	fence_eval #(.NF(NF)) u_eval (
		.clk_i (REF_CLK_I),
		.rst_i (RST_I),
		.m     (fif.eval)
	);

	fence_pin u_pin (
		.clk_i    (REF_CLK_I),
		.rst_i    (RST_I),
		.pin_en_i (q.pin_en),
		.pol_i    (q.fence_pin_polarity),
		.backup_i (q.backup),
		.comb_i   (fif.comb),
		.pin_o    (pin_q)
	);

	// Bus answers
	sequence s_wr_take;
		S_AXI_AWVALID_I && q.awready && S_AXI_WVALID_I && q.wready;
	endsequence
	sequence s_wr_answer;
		!q.bvalid ##1 q.bvalid;
	endsequence
	property p_write_answer;
		@(posedge REF_CLK_I) disable iff (RST_I) s_wr_take |=> s_wr_answer;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	property p_write_reopen;
		@(posedge REF_CLK_I) disable iff (RST_I)
			q.bvalid && S_AXI_BREADY_I |=> q.awready && q.wready;
	endproperty
	a_write_reopen: assert property (p_write_reopen) else $error("write not reopened");
	property p_read_answer;
		@(posedge REF_CLK_I) disable iff (RST_I) S_AXI_ARVALID_I && q.arready |=> q.rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_read_reopen;
		@(posedge REF_CLK_I) disable iff (RST_I) q.rvalid && S_AXI_RREADY_I |=> q.arready;
	endproperty
	a_read_reopen: assert property (p_read_reopen) else $error("read not reopened");

	// Event flags, set wins over a clear in the same cycle
	property p_report_flag;
		@(posedge REF_CLK_I) disable iff (RST_I) fif.done |=> q.irq_sts[`IRQ_REPORT];
	endproperty
	a_report_flag: assert property (p_report_flag) else $error("report flag lost");
	property p_change_flag;
		@(posedge REF_CLK_I) disable iff (RST_I)
			fif.done && fif.comb != q.comb_prev |=> q.irq_sts[`IRQ_CHANGE];
	endproperty
	a_change_flag: assert property (p_change_flag) else $error("change flag lost");

	assign S_AXI_AWREADY_O = q.awready;
	assign S_AXI_WREADY_O = q.wready;
	assign S_AXI_BRESP_O = q.bresp;
	assign S_AXI_BVALID_O = q.bvalid;
	assign S_AXI_ARREADY_O = q.arready;
	assign S_AXI_RDATA_O = q.rdata;
	assign S_AXI_RRESP_O = q.rresp;
	assign S_AXI_RVALID_O = q.rvalid;
	assign GEOFENCE_PIN_O = pin_q;
	assign IRQ_O = q.irq;
endmodule
`default_nettype wire

// file: tb/fence_host.sv
`timescale 1ns/100ps
`default_nettype none
module fence_host (
	// Clock
	input wire logic         clk_i,
	// AXI4-Lite master side
	output logic [7:0]       awaddr_o,
	output logic             awvalid_o,
	input wire logic         awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input wire logic         wready_i,
	input wire logic [1:0]   bresp_i,
	input wire logic         bvalid_i,
	output logic             bready_o,
	output logic [7:0]       araddr_o,
	output logic             arvalid_o,
	input wire logic         arready_i,
	input wire logic [31:0]  rdata_i,
	input wire logic [1:0]   rresp_i,
	input wire logic         rvalid_i,
	output logic             rready_o,
	// Wake pin
	input wire logic         pin_i,
	output logic             pin_seen_o
);
	// Host watches the pin it selected by I/O index, not by package pin
	assign pin_seen_o = pin_i;

	initial begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		@(posedge clk_i);
		awaddr_o  <= a;
		wdata_o   <= d;
		wstrb_o   <= s;
		awvalid_o <= 1'b1;
		wvalid_o  <= 1'b1;
		bready_o  <= 1'b1;
		r = 2'h3;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_i);
			if (awvalid_o && awready_i)
				awvalid_o <= 1'b0;
			if (wvalid_o && wready_i)
				wvalid_o <= 1'b0;
			if (bvalid_i) begin
				r = bresp_i;
				bready_o <= 1'b0;
				break;
			end
		end
		if (n == 64)
			geofence_state_evaluator_tb_top.hang();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_i);
		araddr_o  <= a;
		arvalid_o <= 1'b1;
		rready_o  <= 1'b1;
		d = '0;
		r = 2'h3;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_i);
			if (arvalid_o && arready_i)
				arvalid_o <= 1'b0;
			if (rvalid_i) begin
				d = rdata_i;
				r = rresp_i;
				rready_o <= 1'b0;
				break;
			end
		end
		if (n == 64)
			geofence_state_evaluator_tb_top.hang();
	endtask
endmodule
`default_nettype wire

// file: tb/geofence_state_evaluator_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fence_cfg.svh"
module geofence_state_evaluator_tb_top;
	logic        clk, rst, epoch, pvalid, pin, pin_seen, irq;
	logic [15:0] px, py, pstd;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          err_count = 0;
	int          total_checks = 0;

	geofence_state_evaluator #(.NF(4)) DUT (
		.REF_CLK_I(clk), .RST_I(rst),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .EPOCH_I(epoch),
		.POS_VALID_I(pvalid), .POS_X_I(px), .POS_Y_I(py), .POS_STD_I(pstd),
		.GEOFENCE_PIN_O(pin), .IRQ_O(irq)
	);

	fence_host u_host (
		.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
		.wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
		.bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
		.rvalid_i(rvalid), .rready_o(rready), .pin_i(pin), .pin_seen_o(pin_seen)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic end_of_test();
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic hang();
		err_count++;
		end_of_test();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		u_host.wr(a, d, 4'hF, resp);
		chk({30'h0, resp}, {30'h0, er});
	endtask

	task automatic rdx(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		u_host.rd(a, d, resp);
		chk(d, ed);
		chk({30'h0, resp}, {30'h0, er});
	endtask

	// One epoch pulse, then wait until status, irq and pin have all landed
	task automatic ep(input logic [15:0] x, input logic [15:0] y, input logic v);
		@(posedge clk);
		epoch  <= 1'b1;
		px     <= x;
		py     <= y;
		pstd   <= 16'h000A;
		pvalid <= v;
		@(posedge clk);
		epoch <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		chk({31'h0, pin_seen}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rdx(`REG_SIGMA, 32'h1, `RESP_OKAY);
		rdx(`REG_CTRL, 32'h0, `RESP_OKAY);
	endtask

	task automatic t_bus();
		rdx(8'h18, 32'h0, `RESP_SLVERR);
		rdx(8'h02, 32'h0, `RESP_SLVERR);
		wrx(8'h3C, 32'h0000FFFF, `RESP_SLVERR);
		wrx(`REG_STATUS, 32'h000007FF, `RESP_OKAY);
		rdx(`REG_STATUS, 32'h0, `RESP_OKAY);
		rdx(`REG_IRQ_CLR, 32'h0, `RESP_OKAY);
		u_host.wr(`REG_SIGMA, 32'h00000007, 4'hE, resp);
		chk({30'h0, resp}, {30'h0, `RESP_OKAY});
		rdx(`REG_SIGMA, 32'h1, `RESP_OKAY);
		u_host.wr(`REG_SIGMA, 32'h00000007, 4'h1, resp);
		chk({30'h0, resp}, {30'h0, `RESP_OKAY});
		rdx(`REG_SIGMA, 32'h7, `RESP_OKAY);
	endtask

	task automatic t_idle();
		ep(16'h0000, 16'h0000, 1'b1);
		rdx(`REG_STATUS, 32'h0, `RESP_OKAY);
		rdx(`REG_IRQ_STS, 32'h0, `RESP_OKAY);
	endtask

	task automatic t_cfg();
		logic [15:0] fx [4] = '{16'h0000, 16'h03E8, 16'hFC18, 16'h0000};
		logic [15:0] fy [4] = '{16'h0000, 16'h0000, 16'h0000, 16'hFC18};
		for (int i = 0; i < 4; i++) begin
			wrx(8'(`FENCE_BASE + 8'h10 * i), {16'h0, fx[i]}, `RESP_OKAY);
			wrx(8'(`FENCE_BASE + 8'h10 * i + 4), {16'h0, fy[i]}, `RESP_OKAY);
			wrx(8'(`FENCE_BASE + 8'h10 * i + 8), 32'h00000064, `RESP_OKAY);
		end
	endtask

	// Case word: ctrl, sigma, x, y, {valid, pin}, expected status
	task automatic t_eval();
		logic [63:0] tv [10] = '{
			64'h0_1F_1_0000_0000_8_6A5, 64'h0_1F_1_FC18_0000_8_669,
			64'h0_1F_1_01F4_01F4_C_6AA, 64'h0_3F_1_01F4_01F4_8_6AA,
			64'h0_3F_1_0000_0000_C_6A5, 64'h0_3F_6_0032_0000_C_6A0,
			64'h0_3F_1_0000_0000_4_400, 64'h0_13_1_01F4_01F4_C_42A,
			64'h0_0F_1_0000_0000_C_6A5, 64'h0_5F_1_0000_0000_C_6A5};
		for (int i = 0; i < 10; i++) begin
			wrx(`REG_CTRL, {24'h0, tv[i][59:52]}, `RESP_OKAY);
			wrx(`REG_SIGMA, {28'h0, tv[i][51:48]}, `RESP_OKAY);
			ep(tv[i][47:32], tv[i][31:16], tv[i][15]);
			chk({31'h0, pin_seen}, {31'h0, tv[i][14]});
			rdx(`REG_STATUS, {20'h0, tv[i][11:0]}, `RESP_OKAY);
		end
	endtask

	task automatic t_irq();
		wrx(`REG_IRQ_CLR, 32'h3, `RESP_OKAY);
		wrx(`REG_IRQ_EN, 32'h1, `RESP_OKAY);
		ep(16'h0000, 16'h0000, 1'b1);
		chk({31'h0, irq}, 32'h1);
		rdx(`REG_IRQ_STS, 32'h1, `RESP_OKAY);
		wrx(`REG_IRQ_EN, 32'h0, `RESP_OKAY);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wrx(`REG_IRQ_EN, 32'h1, `RESP_OKAY);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		ep(16'h0000, 16'h0000, 1'b0);
		rdx(`REG_IRQ_STS, 32'h3, `RESP_OKAY);
		wrx(`REG_IRQ_CLR, 32'h3, `RESP_OKAY);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdx(`REG_IRQ_STS, 32'h0, `RESP_OKAY);
	endtask

	task automatic t_mask_rst();
		wrx(`REG_CTRL, 32'h0, `RESP_OKAY);
		rdx(`REG_STATUS, 32'h0, `RESP_OKAY);
		wrx(`REG_CTRL, 32'h1F, `RESP_OKAY);
		ep(16'h0000, 16'h0000, 1'b1);
		chk({31'h0, pin_seen}, 32'h0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, pin_seen}, 32'h1);
		@(posedge clk);
		rst <= 1'b0;
		rdx(`REG_SIGMA, 32'h1, `RESP_OKAY);
		rdx(`REG_STATUS, 32'h0, `RESP_OKAY);
	endtask

	initial begin
		rst    = 1'b1;
		epoch  = 1'b0;
		pvalid = 1'b0;
		px     = 16'h0000;
		py     = 16'h0000;
		pstd   = 16'h0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_bus();
		t_idle();
		t_cfg();
		t_eval();
		t_irq();
		t_mask_rst();
		end_of_test();
	end
endmodule
`default_nettype wire
